// ### src/can_flags_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants of the transmit status and receive queue flag block
// ----------------------------------------------------------------------------
package can_flags_pkg;

    // ------------------------------------------------------------------------
    // Register byte offsets on the APB port
    // ------------------------------------------------------------------------
    localparam logic [11:0] OFS_TX_STATUS = 12'h008;
    localparam logic [11:0] OFS_RXQ0 = 12'h00C;
    localparam logic [11:0] OFS_RXQ1 = 12'h010;
    localparam logic [11:0] OFS_MBOX0_IDENT = 12'h020;
    localparam logic [11:0] OFS_MBOX1_IDENT = 12'h024;

    // ------------------------------------------------------------------------
    // Transmit status field positions, relative to a mailbox's byte
    // ------------------------------------------------------------------------
    localparam int MBOX_STRIDE = 8;
    localparam int DONE_POS = 0;
    localparam int DONE_OK_POS = 1;
    localparam int ARB_LOST_POS = 2;
    localparam int TX_ERR_POS = 3;
    localparam int ABORT_POS = 7;
    localparam int NUM_MBOX = 2;

    // Transmit request bit inside a mailbox identifier register.
    localparam int TX_REQ_POS = 0;

    // ------------------------------------------------------------------------
    // Receive queue register field positions and geometry
    // ------------------------------------------------------------------------
    localparam int RXQ_RELEASE_POS = 5;
    localparam int RXQ_OVERRUN_POS = 4;
    localparam int RXQ_FULL_POS = 3;
    localparam int RXQ_COUNT_LSB = 0;
    localparam int RXQ_DEPTH = 3;
    localparam int NUM_RXQ = 2;

    // ------------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------------
    localparam logic [31:0] RXQ_RESET = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

// ### src/rx_queue_flags.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Fill level and flags of one receive queue
// ----------------------------------------------------------------------------
module rx_queue_flags import can_flags_pkg::*; #(
    parameter int DEPTH = RXQ_DEPTH,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    // Clock, reset and enable.
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Software strobes, one cycle each.
    input wire logic set_release_i,
    input wire logic clr_overrun_i,
    input wire logic clr_full_i,
    // Frame storage side.
    input wire logic frame_in_i,
    output logic pop_o,
    output logic drop_o,
    // Register view.
    output logic [CNT_W-1:0] frame_count_o,
    output logic full_o,
    output logic overrun_o,
    output logic release_o
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic full;
        logic overrun;
        logic release_req;
    } rxq_state_t;

    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] CNT_NEAR = CNT_W'(DEPTH - 1);

    rxq_state_t cur;
    rxq_state_t next_cur;
    logic room;
    logic accept;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------

    // A pending release frees a slot in the same cycle, so a frame arriving
    // then is still taken even if the queue was full.
    always_comb begin
        next_cur = cur;
        pop_o = cur.release_req && (cur.count != '0);
        room = (cur.count < CNT_MAX) || pop_o;
        accept = frame_in_i && room;
        drop_o = frame_in_i && !room;
        next_cur.count = cur.count + CNT_W'(accept) - CNT_W'(pop_o);
        // Removal takes one cycle, so the request clears right after it.
        if (cur.release_req) begin
            next_cur.release_req = 1'b0;
        end
        if (set_release_i) begin
            next_cur.release_req = 1'b1;
        end
        if (clr_full_i) begin
            next_cur.full = 1'b0;
        end
        if (accept && !pop_o && (cur.count == CNT_NEAR)) begin
            next_cur.full = 1'b1;
        end
        if (clr_overrun_i) begin
            next_cur.overrun = 1'b0;
        end
        if (drop_o) begin
            next_cur.overrun = 1'b1;
        end
    end

    // State register; the clear value is all zero.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cur <= '0;
        end else if (ce_i) begin
            cur <= next_cur;
        end
    end

    assign frame_count_o = cur.count;
    assign full_o = cur.full;
    assign overrun_o = cur.overrun;
    assign release_o = cur.release_req;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    overrun_set_a: assert property (ce_i && drop_o |=> overrun_o)
        else $error("Dropped frame did not raise overrun.");
    overrun_hold_a: assert property (overrun_o && !clr_overrun_i && ce_i |=> overrun_o)
        else $error("Overrun flag fell without a software clear.");
    full_set_a: assert property (
        ce_i && frame_in_i && !pop_o && cur.count == CNT_NEAR |=> full_o && cur.count == CNT_MAX)
        else $error("Queue reached its depth without the full flag.");
    count_bound_a: assert property (cur.count <= CNT_MAX)
        else $error("Frame count above queue depth.");
    release_done_a: assert property (
        ce_i && release_o && !set_release_i |=> !release_o)
        else $error("Release request did not clear after removal.");
    drop_keeps_a: assert property (ce_i && drop_o |=> cur.count == $past(cur.count))
        else $error("Dropped frame changed the stored count.");

endmodule

// ### src/can_tx_rx_flags.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps

module can_tx_rx_flags import can_flags_pkg::*; (
    // Clock, reset and enable.
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Protocol engine events, one bit per mailbox.
    input wire logic [NUM_MBOX-1:0] tx_start_i,
    input wire logic [NUM_MBOX-1:0] tx_done_ok_i,
    input wire logic [NUM_MBOX-1:0] tx_done_err_i,
    input wire logic [NUM_MBOX-1:0] tx_aborted_i,
    input wire logic [NUM_MBOX-1:0] tx_error_i,
    input wire logic [NUM_MBOX-1:0] arb_lost_i,
    input wire logic [NUM_MBOX-1:0] mbox_empty_i,
    // Requests to the protocol engine.
    output logic [NUM_MBOX-1:0] tx_request_o,
    output logic mbox0_abort_request_o,
    // Receive frame storage.
    input wire logic [NUM_RXQ-1:0] rx_frame_in_i,
    output logic [NUM_RXQ-1:0] rx_pop_o,
    output logic [NUM_RXQ-1:0] rx_drop_o
);

    // ------------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_MBOX-1:0] done;
        logic [NUM_MBOX-1:0] done_ok;
        logic [NUM_MBOX-1:0] arb_lost;
        logic [NUM_MBOX-1:0] tx_err;
        logic abort0;
        logic [NUM_MBOX-1:0] tx_req;
        logic rd_valid;
        logic [31:0] rdata;
    } tx_state_t;

    tx_state_t cur;
    tx_state_t next_cur;

    logic wr_access;
    logic rd_capture;
    logic wr_status;
    logic [NUM_MBOX-1:0] req_wr;
    logic [NUM_MBOX-1:0] clr_done;
    logic [NUM_RXQ-1:0] wr_rxq;
    logic [1:0] rxq_count [NUM_RXQ];
    logic [NUM_RXQ-1:0] rxq_full;
    logic [NUM_RXQ-1:0] rxq_overrun;
    logic [NUM_RXQ-1:0] rxq_release;

    // Address match against one register offset; used by read and write.
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
        return addr == ofs;
    endfunction

    // Any register that this block answers for.
    function automatic logic mapped(input logic [11:0] addr);
        return hit(addr, OFS_TX_STATUS) || hit(addr, OFS_RXQ0) || hit(addr, OFS_RXQ1)
            || hit(addr, OFS_MBOX0_IDENT) || hit(addr, OFS_MBOX1_IDENT);
    endfunction

    // Receive queue register word; reserved bits read as zero.
    function automatic logic [31:0] rxq_word(input logic [1:0] cnt, input logic full,
                                             input logic ovr, input logic rel);
        logic [31:0] w;
        w = RXQ_RESET;
        w[RXQ_COUNT_LSB +: 2] = cnt;
        w[RXQ_FULL_POS] = full;
        w[RXQ_OVERRUN_POS] = ovr;
        w[RXQ_RELEASE_POS] = rel;
        return w;
    endfunction

    // ------------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------------

    // The slave adds no wait state of its own while the clock runs, but it
    // stalls the bus while the clock enable is low so that no write is lost
    // during a freeze. A read completes only once its data were captured on
    // a running clock; a freeze over the setup phase costs one extra cycle.
    assign pready_o = ce_i && (pwrite_i || cur.rd_valid);
    assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);
    assign wr_access = psel_i && penable_i && pwrite_i && ce_i;
    assign rd_capture = psel_i && !pwrite_i && !cur.rd_valid;
    assign wr_status = wr_access && hit(paddr_i, OFS_TX_STATUS);
    assign wr_rxq[0] = wr_access && hit(paddr_i, OFS_RXQ0);
    assign wr_rxq[1] = wr_access && hit(paddr_i, OFS_RXQ1);

    // ------------------------------------------------------------------------
    // Next state of the mailbox flags and read data
    // ------------------------------------------------------------------------

    // Hardware events are applied after software clears, so an event in the
    // clearing cycle survives.
    always_comb begin
        next_cur = cur;
        req_wr = '0;
        clr_done = '0;
        for (int i = 0; i < NUM_MBOX; i++) begin
            clr_done[i] = wr_status && pwdata_i[i * MBOX_STRIDE + DONE_POS];
            next_cur.tx_req[i] = 1'b0;
        end
        req_wr[0] = wr_access && hit(paddr_i, OFS_MBOX0_IDENT) && pwdata_i[TX_REQ_POS];
        req_wr[1] = wr_access && hit(paddr_i, OFS_MBOX1_IDENT) && pwdata_i[TX_REQ_POS];
        for (int i = 0; i < NUM_MBOX; i++) begin
            next_cur.tx_req[i] = req_wr[i];
            // Finished flag.
            if (clr_done[i] || req_wr[i]) begin
                next_cur.done[i] = 1'b0;
            end
            if (tx_done_ok_i[i] || tx_done_err_i[i] || tx_aborted_i[i]) begin
                next_cur.done[i] = 1'b1;
            end
            // Finished without error.
            if (clr_done[i] || tx_done_err_i[i]
                || (wr_status && pwdata_i[i * MBOX_STRIDE + DONE_OK_POS])) begin
                next_cur.done_ok[i] = 1'b0;
            end
            if (tx_done_ok_i[i]) begin
                next_cur.done_ok[i] = 1'b1;
            end
            // Transmit error.
            if (clr_done[i] || tx_start_i[i]
                || (wr_status && pwdata_i[i * MBOX_STRIDE + TX_ERR_POS])) begin
                next_cur.tx_err[i] = 1'b0;
            end
            if (tx_error_i[i]) begin
                next_cur.tx_err[i] = 1'b1;
            end
            // Arbitration lost.
            if (clr_done[i] || tx_start_i[i]
                || (wr_status && pwdata_i[i * MBOX_STRIDE + ARB_LOST_POS])) begin
                next_cur.arb_lost[i] = 1'b0;
            end
            if (arb_lost_i[i]) begin
                next_cur.arb_lost[i] = 1'b1;
            end
        end
        // Abort request: an empty mailbox has nothing to stop, so the
        // hardware clear takes priority over the software set.
        if (wr_status && pwdata_i[ABORT_POS]) begin
            next_cur.abort0 = 1'b1;
        end
        if (mbox_empty_i[0]) begin
            next_cur.abort0 = 1'b0;
        end
        // The capture flag lives for one read, from capture to completion.
        if (psel_i && penable_i && pready_o) begin
            next_cur.rd_valid = 1'b0;
        end
        if (rd_capture) begin
            next_cur.rd_valid = 1'b1;
        end
        // Read data is captured once per read and stands until the next one.
        if (rd_capture) begin
            next_cur.rdata = RDATA_RESET;
            if (hit(paddr_i, OFS_TX_STATUS)) begin
                for (int i = 0; i < NUM_MBOX; i++) begin
                    next_cur.rdata[i * MBOX_STRIDE + DONE_POS] = cur.done[i];
                    next_cur.rdata[i * MBOX_STRIDE + DONE_OK_POS] = cur.done_ok[i];
                    next_cur.rdata[i * MBOX_STRIDE + ARB_LOST_POS] = cur.arb_lost[i];
                    next_cur.rdata[i * MBOX_STRIDE + TX_ERR_POS] = cur.tx_err[i];
                end
                next_cur.rdata[ABORT_POS] = cur.abort0;
            end
            if (hit(paddr_i, OFS_RXQ0)) begin
                next_cur.rdata = rxq_word(rxq_count[0], rxq_full[0], rxq_overrun[0],
                                          rxq_release[0]);
            end
            if (hit(paddr_i, OFS_RXQ1)) begin
                next_cur.rdata = rxq_word(rxq_count[1], rxq_full[1], rxq_overrun[1],
                                          rxq_release[1]);
            end
            // The request bit reads back as the mailbox being occupied.
            if (hit(paddr_i, OFS_MBOX0_IDENT)) begin
                next_cur.rdata[TX_REQ_POS] = !mbox_empty_i[0];
            end
            if (hit(paddr_i, OFS_MBOX1_IDENT)) begin
                next_cur.rdata[TX_REQ_POS] = !mbox_empty_i[1];
            end
        end
    end

    // State register.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cur <= '0;
        end else if (ce_i) begin
            cur <= next_cur;
        end
    end

    assign prdata_o = cur.rdata;
    assign tx_request_o = cur.tx_req;
    assign mbox0_abort_request_o = cur.abort0;

    // ------------------------------------------------------------------------
    // Receive queues
    // ------------------------------------------------------------------------

    // Software writes are one-cycle strobes; reserved bits are ignored.
    generate
        for (genvar q = 0; q < NUM_RXQ; q++) begin : g_rxq
            rx_queue_flags #(
                .DEPTH(RXQ_DEPTH),
                .CNT_W(2)
            ) u_rxq (
                .clock_i(clock_i),
                .reset_i(reset_i),
                .ce_i(ce_i),
                .set_release_i(wr_rxq[q] && pwdata_i[RXQ_RELEASE_POS]),
                .clr_overrun_i(wr_rxq[q] && pwdata_i[RXQ_OVERRUN_POS]),
                .clr_full_i(wr_rxq[q] && pwdata_i[RXQ_FULL_POS]),
                .frame_in_i(rx_frame_in_i[q]),
                .pop_o(rx_pop_o[q]),
                .drop_o(rx_drop_o[q]),
                .frame_count_o(rxq_count[q]),
                .full_o(rxq_full[q]),
                .overrun_o(rxq_overrun[q]),
                .release_o(rxq_release[q])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    done_set_a: assert property (ce_i && tx_aborted_i[0] |=> cur.done[0])
        else $error("Abort did not set the finished flag.");
    done_req_a: assert property (
        ce_i && req_wr[1] && !tx_done_ok_i[1] && !tx_done_err_i[1] && !tx_aborted_i[1]
        |=> !cur.done[1] && tx_request_o[1])
        else $error("Transmit request left the finished flag set.");
    // Software clears of the finished flag win only without a same-cycle event.
    done_clear_a: assert property (
        clr_done[1] && !tx_done_ok_i[1] && !tx_done_err_i[1] && !tx_aborted_i[1]
        |=> !cur.done[1])
        else $error("Finished-flag write did not clear it.");
    ok_clear_a: assert property (ce_i && tx_done_err_i[0] && !tx_done_ok_i[0]
        |=> !cur.done_ok[0] && cur.done[0])
        else $error("Error finish left done-ok set.");
    ok_set_a: assert property (ce_i && tx_done_ok_i[1] |=> cur.done_ok[1] && cur.done[1])
        else $error("Clean finish did not set both flags.");
    err_start_a: assert property (ce_i && tx_start_i[0] && !tx_error_i[0] |=> !cur.tx_err[0])
        else $error("Transmit start left the error flag set.");
    // Hardware sets; each of these wins over a clear in the same cycle.
    err_set_a: assert property (ce_i && tx_error_i[0] |=> cur.tx_err[0])
        else $error("Transmit error did not set the error flag.");
    arb_clear_a: assert property (
        ce_i && clr_done[0] && !arb_lost_i[0] |=> !cur.arb_lost[0])
        else $error("Finished-flag write left arbitration-lost set.");
    arb_set_a: assert property (ce_i && arb_lost_i[0] |=> cur.arb_lost[0])
        else $error("Lost arbitration did not set its flag.");
    abort_clear_a: assert property (ce_i && mbox_empty_i[0] |=> !mbox0_abort_request_o)
        else $error("Abort request stayed set on an empty mailbox.");
    abort_set_a: assert property (
        wr_status && pwdata_i[ABORT_POS] && !mbox_empty_i[0] |=> mbox0_abort_request_o)
        else $error("Stop write did not raise the abort request.");
    rxq_reset_a: assert property (
        $past(reset_i) |-> rxq_count[0] == 2'h0 && !rxq_full[1] && !rxq_overrun[0])
        else $error("Queue register not zero after reset.");
    drop_full_a: assert property (rx_drop_o[0] |-> rxq_count[0] == 2'(RXQ_DEPTH))
        else $error("Frame dropped from a queue that was not full.");
    // A frozen block must hold the bus rather than complete a transfer.
    bus_freeze_a: assert property (!ce_i |-> !pready_o)
        else $error("Bus completed while the clock enable was low.");

endmodule

// ### tb/can_engine_model.sv
`timescale 1ns/1ps

// ------------------------------------------------
// Protocol engine stand-in for mailbox transfers
// ------------------------------------------------
module can_engine_model import can_flags_pkg::*; (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_i,
    // Requests and bench outcome commands.
    input wire logic [NUM_MBOX-1:0] tx_request_i,
    input wire logic abort_i,
    input wire logic [NUM_MBOX-1:0] finish_ok_i,
    input wire logic [NUM_MBOX-1:0] finish_err_i,
    // Events towards the flag block.
    output logic [NUM_MBOX-1:0] tx_start_o,
    output logic [NUM_MBOX-1:0] tx_done_ok_o,
    output logic [NUM_MBOX-1:0] tx_done_err_o,
    output logic [NUM_MBOX-1:0] tx_aborted_o,
    output logic [NUM_MBOX-1:0] mbox_empty_o
);
    logic [NUM_MBOX-1:0] busy;
    logic [NUM_MBOX-1:0] stop;
    logic [NUM_MBOX-1:0] fin;

    // Outcomes only count for a loaded mailbox, so stray commands cannot fake a finish.
    assign stop = {1'b0, abort_i & busy[0]};
    assign fin = (finish_ok_i | finish_err_i) & busy;
    assign mbox_empty_o = ~busy;

    // Start follows a request by one cycle; the abort empties mailbox 0.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            busy <= '0;
            tx_start_o <= '0;
            tx_done_ok_o <= '0;
            tx_done_err_o <= '0;
            tx_aborted_o <= '0;
        end else begin
            tx_start_o <= tx_request_i;
            tx_done_ok_o <= finish_ok_i & busy;
            tx_done_err_o <= finish_err_i & busy;
            tx_aborted_o <= stop;
            busy <= (busy | tx_request_i) & ~fin & ~stop;
        end
    end
endmodule

// ### tb/can_tx_status_rx_fifo_flags_tb.sv
`timescale 1ns/1ps

module can_tx_status_rx_fifo_flags_tb import can_flags_pkg::*; ;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic abort_req;
    logic [1:0] tx_error = 2'h0;
    logic [1:0] arb_lost = 2'h0;
    logic [1:0] rx_frame = 2'h0;
    logic [1:0] cmd_ok = 2'h0;
    logic [1:0] cmd_err = 2'h0;
    logic [1:0] start, d_ok, d_err, aborted, empty, tx_req, rx_pop, rx_drop;
    int num_errors = 0;
    int checks = 0;

    always #5 clock_i = ~clock_i;

    can_tx_rx_flags u_can_tx_rx_flags (
        .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_start_i(start),
        .tx_done_ok_i(d_ok), .tx_done_err_i(d_err), .tx_aborted_i(aborted),
        .tx_error_i(tx_error), .arb_lost_i(arb_lost), .mbox_empty_i(empty),
        .tx_request_o(tx_req), .mbox0_abort_request_o(abort_req),
        .rx_frame_in_i(rx_frame), .rx_pop_o(rx_pop), .rx_drop_o(rx_drop)
    );

    can_engine_model u_can_engine_model (
        .clock_i(clock_i), .reset_i(reset_i), .tx_request_i(tx_req),
        .abort_i(abort_req), .finish_ok_i(cmd_ok), .finish_err_i(cmd_err),
        .tx_start_o(start), .tx_done_ok_o(d_ok), .tx_done_err_o(d_err),
        .tx_aborted_o(aborted), .mbox_empty_o(empty)
    );

    // ------------------------------------------------
    // Shared helpers
    // ------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic err);
        int n;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check({31'h0, pready}, 32'h1, "bus answer");
        rd = prdata;
        check({31'h0, pslverr}, {31'h0, err}, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000, 1'b0);
        check(rd, exp, what);
    endtask

    // Waits a bounded time for the engine to load or empty a mailbox.
    task automatic wait_empty(input int m, input logic v);
        int n;
        n = 0;
        while (empty[m] !== v && n < 20) begin
            @(posedge clock_i);
            n++;
        end
        check({31'h0, empty[m]}, {31'h0, v}, "mailbox state");
    endtask

    // Event pulse of one cycle: k is {arb lost, tx error, finish err, finish ok}.
    task automatic evt(input logic [3:0] k, input int m);
        @(posedge clock_i);
        cmd_ok[m] <= k[0];
        cmd_err[m] <= k[1];
        tx_error[m] <= k[2];
        arb_lost[m] <= k[3];
        @(posedge clock_i);
        cmd_ok[m] <= 1'b0;
        cmd_err[m] <= 1'b0;
        tx_error[m] <= 1'b0;
        arb_lost[m] <= 1'b0;
    endtask

    task automatic request(input int m);
        apb(1'b1, OFS_MBOX0_IDENT + 12'(4 * m), 32'h0000_0001, 1'b0);
        wait_empty(m, 1'b0);
    endtask

    task automatic frame(input int q, input logic drop);
        @(posedge clock_i);
        rx_frame[q] <= 1'b1;
        #1 check({31'h0, rx_drop[q]}, {31'h0, drop}, "frame drop");
        @(posedge clock_i);
        rx_frame[q] <= 1'b0;
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic test_reset();
        rdchk(OFS_RXQ0, 32'h0000_0000, "queue 0 reset");
        rdchk(OFS_RXQ1, 32'h0000_0000, "queue 1 reset");
        rdchk(OFS_TX_STATUS, 32'h0000_0000, "status reset");
        apb(1'b0, 12'hFFC, 32'h0000_0000, 1'b1);
        check(rd, 32'h0000_0000, "unmapped read");
        $display("test reset done");
    endtask

    // Success, re-request and write-one clear on both mailboxes.
    task automatic test_tx_ok();
        for (int m = 0; m < 2; m++) begin
            request(m);
            evt(4'h1, m);
            rdchk(OFS_TX_STATUS, 32'h3 << (8 * m), "done ok");
            request(m);
            rdchk(OFS_TX_STATUS, 32'h2 << (8 * m), "done cleared");
            evt(4'h1, m);
            apb(1'b1, OFS_TX_STATUS, 32'h1 << (8 * m), 1'b0);
            rdchk(OFS_TX_STATUS, 32'h0000_0000, "w1 done");
        end
        $display("test tx ok done");
    endtask

    task automatic test_tx_err();
        request(0);
        evt(4'h1, 0);
        request(0);
        evt(4'hC, 0);
        evt(4'h2, 0);
        rdchk(OFS_TX_STATUS, 32'h0000_000D, "error end");
        apb(1'b1, OFS_TX_STATUS, 32'h0000_0008, 1'b0);
        rdchk(OFS_TX_STATUS, 32'h0000_0005, "w1 error");
        apb(1'b1, OFS_TX_STATUS, 32'h0000_0004, 1'b0);
        rdchk(OFS_TX_STATUS, 32'h0000_0001, "w1 arb");
        evt(4'hC, 0);
        request(0);
        rdchk(OFS_TX_STATUS, 32'h0000_0000, "start clears");
        evt(4'h1, 0);
        evt(4'hC, 0);
        apb(1'b1, OFS_TX_STATUS, 32'h0000_0001, 1'b0);
        rdchk(OFS_TX_STATUS, 32'h0000_0000, "w1 finish");
        $display("test tx err done");
    endtask

    task automatic test_abort();
        request(0);
        apb(1'b1, OFS_TX_STATUS, 32'h0000_0080, 1'b0);
        #1 check({31'h0, abort_req}, 32'h1, "abort set");
        wait_empty(0, 1'b1);
        rdchk(OFS_TX_STATUS, 32'h0000_0001, "aborted");
        apb(1'b1, OFS_TX_STATUS, 32'h0000_0080, 1'b0);
        rdchk(OFS_TX_STATUS, 32'h0000_0001, "abort empty");
        $display("test abort done");
    endtask

    // Fill past full, clear sticky flags, then release one frame.
    task automatic test_rxq(input int q);
        logic [11:0] a;
        a = OFS_RXQ0 + 12'(4 * q);
        for (int i = 0; i < 3; i++) frame(q, 1'b0);
        rdchk(a, 32'h0000_000B, "full");
        frame(q, 1'b1);
        rdchk(a, 32'h0000_001B, "overrun");
        apb(1'b1, a, 32'h0000_0018, 1'b0);
        rdchk(a, 32'h0000_0003, "w1 flags");
        apb(1'b1, a, 32'h0000_0023, 1'b0);
        #1 check({31'h0, rx_pop[q]}, 32'h1, "pop");
        rdchk(a, 32'h0000_0002, "released");
        $display("test queue %0d done", q);
    endtask

    // A reset in mid-run brings every flag and count back to zero.
    task automatic test_reset_mid();
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        rdchk(OFS_RXQ0, 32'h0000_0000, "queue 0 re-reset");
        rdchk(OFS_RXQ1, 32'h0000_0000, "queue 1 re-reset");
        rdchk(OFS_TX_STATUS, 32'h0000_0000, "status re-reset");
        $display("test mid reset done");
    endtask

    // Frames offered during a freeze are not counted; a read begun then waits.
    task automatic test_freeze();
        @(posedge clock_i);
        ce <= 1'b0;
        rx_frame[0] <= 1'b1;
        fork
            rdchk(OFS_RXQ0, 32'h0000_0000, "frozen count");
            begin
                repeat (3) @(posedge clock_i);
                ce <= 1'b1;
                rx_frame[0] <= 1'b0;
            end
        join
        $display("test freeze done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        test_reset();
        test_tx_ok();
        test_tx_err();
        test_abort();
        test_rxq(0);
        test_rxq(1);
        test_reset_mid();
        test_freeze();
        summarize();
    end

    // The tests need well under a thousand cycles; this cuts a hang short.
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
endmodule
